// [logic/fswp_pkg.sv]
// Shared constants and types of the flash status and write-protect block.
// Assumes a single ref_clk domain; the serial link is sampled, not clocked.
package fswp_pkg;

  // Instruction codes
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_RD_DATA = 8'h03;
  localparam logic [7:0] OP_RD_FAST = 8'h0b;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_PWR_DOWN = 8'hb9;
  localparam logic [7:0] OP_DEV_ID = 8'hab;
  localparam logic [7:0] OP_MFR_DEV_ID = 8'h90;

  // Status field positions
  localparam int BIT_BUSY = 0;
  localparam int BIT_WR_LATCH = 1;
  localparam int BIT_PROT_LO = 2;
  localparam int BIT_PROT_HI = 4;
  localparam int BIT_LOCK = 7;

  // Factory values of the retained bits
  localparam logic [2:0] RST_PROT = 3'h0;
  localparam logic RST_LOCK = 1'b0;

  // Frame byte positions
  localparam logic [2:0] BYTE_STAT_DATA = 3'h1;
  localparam logic [2:0] BYTE_ADDR_LAST = 3'h3;
  localparam logic [2:0] BYTE_ID_FIRST = 3'h3;
  localparam logic [2:0] BYTES_ERASE = 3'h4;
  localparam logic [2:0] BYTES_PROG = 3'h5;
  localparam logic [2:0] BYTES_MAX = 3'h7;

  // Array tops and protected-range bases
  localparam logic [23:0] TOP_1M = 24'h01ffff;
  localparam logic [23:0] TOP_2M = 24'h03ffff;
  localparam logic [23:0] TOP_4M = 24'h07ffff;
  localparam logic [23:0] BASE_4M_EIGHTH = 24'h070000;
  localparam logic [23:0] BASE_4M_QUARTER = 24'h060000;
  localparam logic [23:0] BASE_4M_HALF = 24'h040000;
  localparam logic [23:0] BASE_2M_QUARTER = 24'h030000;
  localparam logic [23:0] BASE_2M_HALF = 24'h020000;
  localparam logic [23:0] BASE_ALL = 24'h000000;

  // Self-timed cycle lengths in ref_clk cycles
  localparam logic [23:0] CYC_STAT_WR = 24'h000400;
  localparam logic [23:0] CYC_PROG = 24'h000200;
  localparam logic [23:0] CYC_SECT = 24'h000800;
  localparam logic [23:0] CYC_CHIP = 24'h001000;

  typedef enum logic [2:0] {
    CYC_NONE, CYC_WRSTAT, CYC_PP, CYC_SE, CYC_CE
  } fswp_cyc_t;

  typedef struct packed {
    logic csM, csQ, csP;
    logic sckM, sckQ, sckP;
    logic sdiM, sdiQ;
    logic wpM, wpQ;
    logic active, ignore, idSel;
    logic [2:0] bitIdx;
    logic [2:0] byteCnt;
    logic [7:0] shIn;
    logic [7:0] opcode;
    logic [7:0] srData;
    logic [23:0] addr;
    logic [7:0] shOut;
    logic doBit, outEnN;
    logic wrLatch, busy, lock;
    logic [2:0] prot;
    logic [23:0] busyCnt;
    fswp_cyc_t cyc;
    logic opValid;
    fswp_cyc_t opKind;
    logic [23:0] opAddr;
  } fswp_state_t;

endpackage

// [logic/fswp_prot_map.sv]
// Block-protect decode: maps the three protect bits to a protected range.
// Assumes the caller presents a byte address of the selected density.
`timescale 1ns/1ps
`default_nettype none
module fswp_prot_map #(
  parameter int DENSITY_MBIT = 4
) (
  input wire logic [2:0] protBits,
  input wire logic [23:0] addr,
  output logic protHit,
  output logic anyProt
);

  localparam logic [23:0] TOP = (DENSITY_MBIT == 4) ? fswp_pkg::TOP_4M :
    (DENSITY_MBIT == 2) ? fswp_pkg::TOP_2M : fswp_pkg::TOP_1M;

  logic [23:0] base;
  logic none;

  always_comb begin
    none = 1'b1;
    base = fswp_pkg::BASE_ALL;
    if (DENSITY_MBIT == 4) begin
      none = (protBits == 3'h0);
      if (!protBits[2]) begin
        case (protBits[1:0])
          2'h1: base = fswp_pkg::BASE_4M_EIGHTH;
          2'h2: base = fswp_pkg::BASE_4M_QUARTER;
          2'h3: base = fswp_pkg::BASE_4M_HALF;
          default: base = fswp_pkg::BASE_ALL;
        endcase
      end
    end else if (DENSITY_MBIT == 2) begin
      none = (protBits[1:0] == 2'h0);
      case (protBits[1:0])
        2'h1: base = fswp_pkg::BASE_2M_QUARTER;
        2'h2: base = fswp_pkg::BASE_2M_HALF;
        default: base = fswp_pkg::BASE_ALL;
      endcase
    end else begin
      none = (protBits[1:0] != 2'h3);
    end
    protHit = !none && ((addr & TOP) >= base);
    anyProt = !none;
  end

endmodule
`default_nettype wire

// [logic/fswp_status_wp.sv]
// Status register, write-enable latch and write protection of a serial
// flash, with instruction framing on chip select.
// Assumes SPI mode 0 or 3 pins from another clock domain, sampled here.
`timescale 1ns/1ps
`default_nettype none
module fswp_status_wp #(
  parameter int DENSITY_MBIT = 4,
  parameter logic [23:0] STAT_WR_CYCLES = fswp_pkg::CYC_STAT_WR,
  parameter logic [23:0] PROG_CYCLES = fswp_pkg::CYC_PROG,
  parameter logic [23:0] SECT_CYCLES = fswp_pkg::CYC_SECT,
  parameter logic [23:0] CHIP_CYCLES = fswp_pkg::CYC_CHIP,
  // Identifier values are arbitrary
  parameter logic [7:0] MFR_ID = 8'ha5,
  parameter logic [7:0] DEV_ID_1M = 8'h31,
  parameter logic [7:0] DEV_ID_2M = 8'h32,
  parameter logic [7:0] DEV_ID_4M = 8'h34
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic chipSelN,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic writeProtN,
  output logic serialOut,
  output logic serialOutEnN,
  output logic arrayOpValid,
  output var fswp_pkg::fswp_cyc_t arrayOpKind,
  output logic [23:0] arrayOpAddr
);

  if (DENSITY_MBIT != 1 && DENSITY_MBIT != 2 &&
      DENSITY_MBIT != 4) begin : g_bad_density
    $error("DENSITY_MBIT must be 1, 2 or 4");
  end
  if (STAT_WR_CYCLES == 24'h0 || PROG_CYCLES == 24'h0 ||
      SECT_CYCLES == 24'h0 || CHIP_CYCLES == 24'h0) begin : g_bad_cycles
    $error("Cycle counts must be nonzero");
  end

  localparam logic [7:0] DEV_ID = (DENSITY_MBIT == 4) ? DEV_ID_4M :
    (DENSITY_MBIT == 2) ? DEV_ID_2M : DEV_ID_1M;

  localparam fswp_pkg::fswp_state_t ST_RST = '{
    outEnN: 1'b1,
    prot: fswp_pkg::RST_PROT,
    lock: fswp_pkg::RST_LOCK,
    cyc: fswp_pkg::CYC_NONE,
    opKind: fswp_pkg::CYC_NONE,
    default: '0
  };

  // Status byte as seen by a reader
  function automatic logic [7:0] statusOf(fswp_pkg::fswp_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[fswp_pkg::BIT_BUSY] = s.busy;
    v[fswp_pkg::BIT_WR_LATCH] = s.wrLatch;
    v[fswp_pkg::BIT_PROT_HI:fswp_pkg::BIT_PROT_LO] = s.prot;
    v[fswp_pkg::BIT_LOCK] = s.lock;
    return v;
  endfunction

  // Instructions that must end on a byte boundary
  function automatic logic isWriteOp(logic [7:0] op);
    return op == fswp_pkg::OP_WR_EN || op == fswp_pkg::OP_WR_DIS ||
      op == fswp_pkg::OP_WR_STAT || op == fswp_pkg::OP_PAGE_PROG ||
      op == fswp_pkg::OP_SECT_ERASE || op == fswp_pkg::OP_CHIP_ERASE;
  endfunction

  fswp_pkg::fswp_state_t st;
  fswp_pkg::fswp_state_t n;

  logic csFall, csRise, sckRise, sckFall, byteDone, cycEnd;
  logic [7:0] inByte, opNow, outVal;
  logic ignoreNow, outLoad;
  logic frameOk, locked, protHit, anyProt;
  logic wrEnGo, wrDisGo, wrStatGo, progGo, sectGo, chipGo;

  fswp_prot_map #(
    .DENSITY_MBIT(DENSITY_MBIT)
  ) u_prot_map (
    .protBits(st.prot),
    .addr(st.addr),
    .protHit(protHit),
    .anyProt(anyProt)
  );

  assign csFall = st.csP && !st.csQ;
  assign csRise = !st.csP && st.csQ;
  assign sckRise = !st.sckP && st.sckQ && !st.csQ && st.active;
  assign sckFall = st.sckP && !st.sckQ && !st.csQ && st.active;
  assign byteDone = sckRise && (st.bitIdx == 3'h7);
  assign inByte = {st.shIn[6:0], st.sdiQ};
  assign opNow = (st.byteCnt == 3'h0) ? inByte : st.opcode;
  assign ignoreNow = (st.byteCnt == 3'h0) ?
    (st.busy && inByte != fswp_pkg::OP_RD_STAT) : st.ignore;
  assign cycEnd = st.busy && (st.busyCnt == 24'h000001);
  assign locked = st.lock && !st.wpQ;

  // Whole bytes only, not busy, not ignored
  assign frameOk = csRise && st.active && !st.ignore && !st.busy &&
    (st.bitIdx == 3'h0) && (st.byteCnt != 3'h0) && isWriteOp(st.opcode);
  assign wrEnGo = frameOk && st.opcode == fswp_pkg::OP_WR_EN;
  assign wrDisGo = frameOk && st.opcode == fswp_pkg::OP_WR_DIS;
  assign wrStatGo = frameOk && st.opcode == fswp_pkg::OP_WR_STAT &&
    st.wrLatch && !locked &&
    st.byteCnt > fswp_pkg::BYTE_STAT_DATA;
  assign progGo = frameOk && st.opcode == fswp_pkg::OP_PAGE_PROG &&
    st.wrLatch && !protHit && st.byteCnt >= fswp_pkg::BYTES_PROG;
  assign sectGo = frameOk && st.opcode == fswp_pkg::OP_SECT_ERASE &&
    st.wrLatch && !protHit && st.byteCnt >= fswp_pkg::BYTES_ERASE;
  assign chipGo = frameOk && st.opcode == fswp_pkg::OP_CHIP_ERASE &&
    st.wrLatch && !anyProt;

  // Next byte to shift out, chosen as a byte completes
  always_comb begin
    outLoad = 1'b0;
    outVal = 8'h00;
    if (byteDone && !ignoreNow) begin
      case (opNow)
        fswp_pkg::OP_RD_STAT: begin
          outLoad = 1'b1;
          outVal = statusOf(st);
        end
        fswp_pkg::OP_MFR_DEV_ID: begin
          outLoad = st.byteCnt >= fswp_pkg::BYTE_ID_FIRST;
          outVal = st.idSel ? DEV_ID : MFR_ID;
        end
        fswp_pkg::OP_DEV_ID: begin
          outLoad = st.byteCnt >= fswp_pkg::BYTE_ID_FIRST;
          outVal = DEV_ID;
        end
        default: outLoad = 1'b0;
      endcase
    end
  end

  always_comb begin
    n = st;
    n.opValid = 1'b0;
    n.csM = chipSelN;
    n.csQ = st.csM;
    n.csP = st.csQ;
    n.sckM = serialClk;
    n.sckQ = st.sckM;
    n.sckP = st.sckQ;
    n.sdiM = serialIn;
    n.sdiQ = st.sdiM;
    n.wpM = writeProtN;
    n.wpQ = st.wpM;

    // Self-timed cycle countdown
    if (st.busy) begin
      n.busyCnt = st.busyCnt - 24'h000001;
      if (cycEnd) begin
        n.busy = 1'b0;
        n.wrLatch = 1'b0;
        n.cyc = fswp_pkg::CYC_NONE;
        if (st.cyc == fswp_pkg::CYC_WRSTAT) begin
          n.prot = st.srData[fswp_pkg::BIT_PROT_HI:fswp_pkg::BIT_PROT_LO];
          n.lock = st.srData[fswp_pkg::BIT_LOCK];
        end
      end
    end

    if (csFall) begin
      n.active = 1'b1;
      n.ignore = 1'b0;
      n.idSel = 1'b0;
      n.bitIdx = 3'h0;
      n.byteCnt = 3'h0;
    end

    if (sckRise) begin
      n.shIn = inByte;
      n.bitIdx = st.bitIdx + 3'h1;
    end

    if (byteDone) begin
      if (st.byteCnt != fswp_pkg::BYTES_MAX) begin
        n.byteCnt = st.byteCnt + 3'h1;
      end
      if (st.byteCnt == 3'h0) begin
        n.opcode = inByte;
        n.ignore = ignoreNow;
      end else if (!st.ignore) begin
        if (st.byteCnt <= fswp_pkg::BYTE_ADDR_LAST) begin
          n.addr = {st.addr[15:0], inByte};
        end
        if (st.byteCnt == fswp_pkg::BYTE_STAT_DATA &&
            st.opcode == fswp_pkg::OP_WR_STAT) begin
          n.srData = inByte;
        end
      end
    end

    if (outLoad) begin
      n.shOut = outVal;
      n.outEnN = 1'b0;
      if (opNow == fswp_pkg::OP_MFR_DEV_ID) begin
        n.idSel = !st.idSel;
      end
    end

    // Output changes on the falling serial clock
    if (sckFall && !st.outEnN) begin
      n.doBit = st.shOut[7];
      n.shOut = {st.shOut[6:0], 1'b0};
    end

    if (csRise) begin
      n.active = 1'b0;
      n.outEnN = 1'b1;
      n.doBit = 1'b0;
    end

    if (wrEnGo) begin
      n.wrLatch = 1'b1;
    end
    if (wrDisGo) begin
      n.wrLatch = 1'b0;
    end
    if (wrStatGo || progGo || sectGo || chipGo) begin
      n.busy = 1'b1;
      n.opAddr = st.addr;
      if (wrStatGo) begin
        n.cyc = fswp_pkg::CYC_WRSTAT;
        n.busyCnt = STAT_WR_CYCLES;
      end else if (progGo) begin
        n.cyc = fswp_pkg::CYC_PP;
        n.busyCnt = PROG_CYCLES;
      end else if (sectGo) begin
        n.cyc = fswp_pkg::CYC_SE;
        n.busyCnt = SECT_CYCLES;
      end else begin
        n.cyc = fswp_pkg::CYC_CE;
        n.busyCnt = CHIP_CYCLES;
      end
      n.opValid = !wrStatGo;
      n.opKind = n.cyc;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else if (clkEn) begin
      st <= n;
    end
  end

  assign serialOut = st.doBit;
  assign serialOutEnN = st.outEnN;
  assign arrayOpValid = st.opValid;
  assign arrayOpKind = st.opKind;
  assign arrayOpAddr = st.opAddr;

  frame_start_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clkEn && csFall |=> st.active && st.bitIdx == 3'h0 &&
      st.byteCnt == 3'h0)
    else $error("Frame did not start on select fall");

  busy_set_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clkEn && (wrStatGo || progGo || sectGo || chipGo) |=>
      st.busy && (statusOf(st) & 8'h01) == 8'h01)
    else $error("Busy not raised for self-timed cycle");

  busy_ignore_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clkEn && byteDone && st.byteCnt == 3'h0 && st.busy &&
      inByte != fswp_pkg::OP_RD_STAT |=> st.ignore ##0 !arrayOpValid)
    else $error("Instruction taken while busy");

  busy_clear_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clkEn && cycEnd |=> !st.busy && !st.wrLatch)
    else $error("Busy or latch left set after cycle");

  latch_set_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clkEn && wrEnGo |=> st.wrLatch)
    else $error("Write enable did not set latch");

  latch_clear_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clkEn && wrDisGo |=> !st.wrLatch)
    else $error("Write disable did not clear latch");

  prot_reject_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clkEn && csRise && !st.busy && protHit &&
      (st.opcode == fswp_pkg::OP_PAGE_PROG ||
       st.opcode == fswp_pkg::OP_SECT_ERASE) |=> !st.busy && !st.opValid)
    else $error("Write into protected range accepted");

  lock_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clkEn && frameOk && st.opcode == fswp_pkg::OP_WR_STAT && locked |=>
      !st.busy && $stable(st.wrLatch))
    else $error("Status write accepted while locked");

  byte_bound_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clkEn && csRise && st.bitIdx != 3'h0 && !st.busy |=>
      !st.busy && $stable(st.wrLatch))
    else $error("Partial-byte write instruction executed");

  enable_need_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clkEn && csRise && !st.wrLatch && !st.busy |=> !st.busy)
    else $error("Write started without enable latch");

  stat_shift_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clkEn && outLoad && opNow == fswp_pkg::OP_RD_STAT |=>
      st.shOut[6:5] == 2'h0 && st.shOut[0] == $past(st.busy) &&
      !serialOutEnN)
    else $error("Status byte loaded wrongly");

endmodule
`default_nettype wire

// [testbench/fswp_spi_host.sv]
// SPI host model: mode 0 frames of up to 64 bits on the flash pins.
// Assumes one frame at a time; serial clock period 16 ref_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module fswp_spi_host (
  input wire logic ref_clk,
  input wire logic serialOut,
  input wire logic serialOutEnN,
  output logic chipSelN,
  output logic serialClk,
  output logic serialIn
);
  logic lastBit;

  initial begin
    chipSelN = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
    lastBit = 1'b0;
  end

  // Frame bit nBits-1 goes first; read bits are taken at each rise
  task automatic xfer(input logic [63:0] txData, input int nBits,
                      output logic [63:0] rxData);
    rxData = '0;
    @(posedge ref_clk);
    chipSelN <= 1'b0;
    for (int i = nBits - 1; i >= 0; i--) begin
      serialIn <= txData[i];
      repeat (8) @(posedge ref_clk);
      serialClk <= 1'b1;
      // Undriven data line shows no stale value
      lastBit = serialOutEnN ? ~lastBit : serialOut;
      rxData = {rxData[62:0], lastBit};
      repeat (8) @(posedge ref_clk);
      serialClk <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    chipSelN <= 1'b1;
    serialIn <= ~txData[0];
    repeat (8) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// [testbench/fswp_status_wp_test.sv]
// Self-checking bench of the flash status and write-protect block.
// Assumes the SPI host model drives the pins; one 4 Mbit instance.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    nCompared++; \
    if ((got) !== (ex)) begin \
      failures++; \
      $display("unexpected %s expected %h seen %h", nm, ex, got); \
    end \
  end
module fswp_status_wp_test;
  localparam logic [7:0] MFR = 8'h5a; // Arbitrary value
  localparam logic [7:0] DEV = 8'h3c; // Arbitrary value
  logic ref_clk, rst_n, clkEn, writeProtN;
  logic chipSelN, serialClk, serialIn, serialOut, serialOutEnN;
  logic arrayOpValid, drove;
  fswp_pkg::fswp_cyc_t arrayOpKind, opKind;
  logic [23:0] arrayOpAddr, opAddr;
  logic [63:0] rx;
  logic [23:0] baseTab [8];
  logic [7:0] quietOps [3];
  int failures = 0;
  int nCompared = 0;
  int nOps = 0;

  fswp_status_wp #(
    .DENSITY_MBIT(4),
    .STAT_WR_CYCLES(24'h0007d0),
    .PROG_CYCLES(24'h0003e8),
    .SECT_CYCLES(24'h0004b0),
    .CHIP_CYCLES(24'h0005dc),
    .MFR_ID(MFR),
    .DEV_ID_4M(DEV)
  ) dut_u (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .chipSelN(chipSelN),
    .serialClk(serialClk),
    .serialIn(serialIn),
    .writeProtN(writeProtN),
    .serialOut(serialOut),
    .serialOutEnN(serialOutEnN),
    .arrayOpValid(arrayOpValid),
    .arrayOpKind(arrayOpKind),
    .arrayOpAddr(arrayOpAddr)
  );

  fswp_spi_host host_u (
    .ref_clk(ref_clk),
    .serialOut(serialOut),
    .serialOutEnN(serialOutEnN),
    .chipSelN(chipSelN),
    .serialClk(serialClk),
    .serialIn(serialIn)
  );

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (arrayOpValid === 1'b1) begin
      nOps++;
      opKind = arrayOpKind;
      opAddr = arrayOpAddr;
    end
    if (serialOutEnN === 1'b0) begin
      drove = 1'b1;
    end
  end

  task automatic send(input logic [63:0] tx, input int n);
    host_u.xfer(tx, n, rx);
  endtask

  task automatic chkStat(input string nm, input logic [7:0] ex);
    send(64'h0500, 16);
    `CHK(nm, ex, rx[7:0])
  endtask

  task automatic waitIdle;
    int i;
    i = 0;
    do begin
      send(64'h0500, 16);
      i++;
    end while (rx[0] !== 1'b0 && i < 40);
    `CHK("busy cleared", 1'b0, rx[0])
  endtask

  task automatic setStat(input logic [7:0] d);
    send(64'h06, 8);
    send({48'h0, 8'h01, d}, 16);
    waitIdle();
  endtask

  task automatic tryOp(input logic [7:0] op, input logic [23:0] a,
                       input int n, input bit ok,
                       input fswp_pkg::fswp_cyc_t k);
    int k0;
    k0 = nOps;
    send(64'h06, 8);
    send({op, a, 32'h0} >> (64 - n), n);
    repeat (4) @(posedge ref_clk);
    `CHK("op accepted", ok ? k0 + 1 : k0, nOps)
    if (ok) begin
      `CHK("op kind", k, opKind)
      if (n > 8) begin
        `CHK("op addr", a, opAddr)
      end
      waitIdle();
    end
  endtask

  task automatic results;
    $display("compared %0d failures %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    failures++;
    results();
  end

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    writeProtN = 1'b1;
    drove = 1'b0;
    baseTab = '{24'h0, 24'h070000, 24'h060000, 24'h040000,
                24'h0, 24'h0, 24'h0, 24'h0};
    quietOps = '{8'h03, 8'h0b, 8'hb9};
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chkStat("reset status", 8'h00);
    send(64'h06, 8);
    chkStat("latch set", 8'h02);
    send(64'h04, 8);
    chkStat("latch clear", 8'h00);
    clkEn <= 1'b0;
    send(64'h06, 8);
    clkEn <= 1'b1;
    chkStat("frozen enable", 8'h00);
    send(64'h060, 12);
    chkStat("partial enable", 8'h00);
    send(64'h050, 12);
    send({48'h0, 8'h01, 8'h0c}, 16);
    chkStat("write no latch", 8'h00);
    send({24'h0, 8'h02, 24'h000100, 8'h00}, 40);
    `CHK("program no latch", 0, nOps)
    send(64'h06, 8);
    send(64'h010c >> 1, 15);
    chkStat("partial status write", 8'h02);
    send({48'h0, 8'h01, 8'h6f}, 16);
    chkStat("busy", 8'h03);
    drove = 1'b0;
    send(64'hab00000000, 40);
    `CHK("busy id", 1'b0, drove)
    send(64'h04, 8);
    chkStat("busy disable", 8'h03);
    waitIdle();
    chkStat("status written", 8'h0c);
    send(64'h05000000, 32);
    `CHK("status repeat", 16'h0c0c, rx[15:0])
    send(64'h90000000000000, 56);
    `CHK("maker id", {MFR, DEV, MFR}, rx[23:0])
    send(64'hab0000000000, 48);
    `CHK("device id", {DEV, DEV}, rx[15:0])
    foreach (quietOps[i]) begin
      drove = 1'b0;
      send({quietOps[i], 32'h0}, 40);
      `CHK("no output", 1'b0, drove)
    end
    chkStat("after quiet ops", 8'h0c);
    writeProtN <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      setStat({3'h0, c[2:0], 2'h0});
      chkStat("protect bits", {3'h0, c[2:0], 2'h0});
      if (c != 0) begin
        tryOp(8'hd8, baseTab[c], 32, 1'b0, fswp_pkg::CYC_SE);
      end
      if (c == 0) begin
        tryOp(8'hd8, 24'h07ffff, 32, 1'b1, fswp_pkg::CYC_SE);
      end else if (baseTab[c] != 24'h0) begin
        tryOp(8'hd8, baseTab[c] - 24'h1, 32, 1'b1,
              fswp_pkg::CYC_SE);
      end
    end
    tryOp(8'hc7, 24'h0, 8, 1'b0, fswp_pkg::CYC_CE);
    tryOp(8'h02, 24'h000100, 40, 1'b0, fswp_pkg::CYC_PP);
    setStat(8'h84);
    chkStat("lock set", 8'h84);
    send(64'h06, 8);
    send({48'h0, 8'h01, 8'h00}, 16);
    chkStat("locked write", 8'h86);
    writeProtN <= 1'b1;
    send({48'h0, 8'h01, 8'h00}, 16);
    waitIdle();
    chkStat("unlocked write", 8'h00);
    tryOp(8'hc7, 24'h0, 8, 1'b1, fswp_pkg::CYC_CE);
    tryOp(8'h02, 24'h012345, 40, 1'b1, fswp_pkg::CYC_PP);
    chkStat("latch after program", 8'h00);
    results();
  end
endmodule
`default_nettype wire
